// >>> pkg/wdt_timer_pkg.sv
package wdt_timer_pkg;
	// Wishbone register offsets (byte addresses)
	localparam logic [3:0] CTRL_ADDR = 4'h0;
	localparam logic [3:0] STATUS_ADDR = 4'h4;
	localparam logic [3:0] RTC_CONTROL_REGISTER_ADDR = 4'h8;
	localparam logic [3:0] CMD_ADDR = 4'hC;
	// Command register bit positions
	localparam int CMD_SINGLE_CLR = 0;
	localparam int CMD_PAIR_FIRST = 1;
	localparam int CMD_PAIR_SECOND = 2;
	localparam int CMD_HALT = 3;
	localparam int CMD_WAKE = 4;
	// Status register bit positions
	localparam int STAT_TIMEOUT = 5;
	localparam int STAT_POWERDOWN = 4;
	localparam int STAT_HALTED = 0;
	// Quick start oscillator bit in the rtc control register
	localparam int QUICK_START_BIT = 4;
	localparam logic [7:0] RTC_CONTROL_REGISTER_RESET = 8'h00;
	// Chain: 8-stage divider then 7-bit prescaler
	localparam int DIV_STAGES = 8;
	localparam int PRESCALE_BITS = 7;
	localparam int CHAIN_BITS = DIV_STAGES + PRESCALE_BITS;
	// Time-out exponent range and tap ranges
	localparam int WDT_EXP_MIN = 12;
	localparam int LCD_EXP_MIN = 2;
	localparam int LCD_EXP_MAX = 8;
	localparam int BUZ_EXP_MIN = 2;
	localparam int BUZ_EXP_MAX = 9;
	// Instruction clock is the system clock divided by this
	localparam int INSTR_DIV = 4;
	// Clock source encodings
	typedef enum logic [1:0] {
		SRC_WATCHDOG_RC_OSCILLATOR = 2'h0,
		SRC_INSTR = 2'h1,
		SRC_RTC_CRYSTAL_OSCILLATOR = 2'h2
	} clk_src_e;
	// Warm reset pulse length in clocks
	localparam logic [7:0] WARM_PULSE = 8'h01;
endpackage : wdt_timer_pkg

// >>> design/wdt_timer.sv
`timescale 1ns/1ns
// Summary of operation
// - Counter clocked by one configured source
// - Disabled watchdog makes its instructions no-ops
// - RC source time-out divides by 2^12..2^15
// - Instruction clock source stops while halted
// - Normal overflow gives chip reset, sets flag
// - Halted overflow gives warm reset instead of chip reset, sets flag
// - Cleared by reset, clear command or halt
// - Option chooses single or paired clear scheme
// - Single clear command clears counter only in the single clear scheme
// - Paired scheme clears after a first then a second command, or two first commands
// - Chain is 8-stage divider plus 7-bit prescaler
// - LCD clock is source over 2^2..2^8
// - Buzzer clock is source over 2^2..2^9
// - Halt stops system oscillator, RTC runs
// - RTC source keeps timing running in halt
// - RC mode outputs system clock over four
// - Quick start bit 4 of rtc control register
// - Option disables the watchdog RC oscillator
// - Halt clears counter and restarts it
// - Flag cleared by power-up, clear, halt
module wdt_timer import wdt_timer_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	// Classic Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Source ticks, one-cycle enables from the oscillators
	input wire logic watchdog_rc_oscillator_tick_i,
	input wire logic rtc_crystal_oscillator_tick_i,
	// Static options, sampled while reset is high
	input wire logic wdt_enable_opt_i,
	input wire logic watchdog_rc_oscillator_enable_opt_i,
	input wire logic [1:0] clk_src_opt_i,
	input wire logic [1:0] timeout_sel_opt_i,
	input wire logic paired_clear_opt_i,
	input wire logic rc_osc_mode_opt_i,
	input wire logic [2:0] lcd_sel_opt_i,
	input wire logic [2:0] buz_sel_opt_i,
	// Outputs
	output logic chip_reset_o,
	output logic warm_reset_o,
	output logic sys_osc_run_o,
	output logic osc_output_pin_o,
	output logic lcd_clk_o,
	output logic buzzer_clk_o,
	output logic quick_start_osc_o,
	output logic timeout_status_flag_o,
	output logic powerdown_flag_o
);

	// Latched options
	logic opt_wdt_en;
	logic opt_osc_en;
	clk_src_e opt_src;
	logic [1:0] opt_tsel;
	logic opt_paired;
	logic opt_rc_mode;
	logic [2:0] opt_lcd;
	logic [2:0] opt_buz;

	// Core state
	logic [CHAIN_BITS-1:0] chain;
	logic [1:0] instr_div;
	logic halted;
	logic pair_first_seen;
	logic [7:0] rtc_control_register;
	logic timeout_flag;
	logic powerdown_flag;
	logic ack;

	// Options only follow the pins during reset, then freeze
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			opt_wdt_en <= wdt_enable_opt_i;
			opt_osc_en <= watchdog_rc_oscillator_enable_opt_i;
			opt_src <= clk_src_e'(clk_src_opt_i);
			opt_tsel <= timeout_sel_opt_i;
			opt_paired <= paired_clear_opt_i;
			opt_rc_mode <= rc_osc_mode_opt_i;
			opt_lcd <= lcd_sel_opt_i;
			opt_buz <= buz_sel_opt_i;
		end
	end

	// Bus decode
	wire bus_req = cyc_i && stb_i && !ack;
	wire bus_wr = bus_req && we_i && sel_i[0];
	wire wr_ctrl_cmd = bus_wr && (adr_i == CMD_ADDR);
	wire wr_rtc_control_register = bus_wr && (adr_i == RTC_CONTROL_REGISTER_ADDR);

	// Clear commands act only when the watchdog is enabled by option; halt and wake always act
	wire cmd_single = wr_ctrl_cmd && dat_i[CMD_SINGLE_CLR] && opt_wdt_en && !opt_paired;
	wire cmd_first = wr_ctrl_cmd && dat_i[CMD_PAIR_FIRST] && opt_wdt_en && opt_paired;
	wire cmd_second = wr_ctrl_cmd && dat_i[CMD_PAIR_SECOND] && opt_wdt_en && opt_paired;
	wire cmd_halt = wr_ctrl_cmd && dat_i[CMD_HALT] && !halted;
	wire cmd_wake = wr_ctrl_cmd && dat_i[CMD_WAKE] && halted;

	// Paired clear fires when a second or repeated first command follows a first, or first and second come in one write
	wire pair_done = (cmd_first && (cmd_second || pair_first_seen)) ||
		(cmd_second && pair_first_seen);
	wire sw_clear = cmd_single || pair_done;
	wire wdt_clear = sw_clear || cmd_halt;

	// Source selection; instruction clock is frozen while halted
	wire instr_tick = (instr_div == 2'(INSTR_DIV - 1)) && !halted;
	wire src_tick = (opt_src == SRC_WATCHDOG_RC_OSCILLATOR) ? (watchdog_rc_oscillator_tick_i && opt_osc_en) :
		(opt_src == SRC_RTC_CRYSTAL_OSCILLATOR) ? rtc_crystal_oscillator_tick_i : instr_tick;

	// Overflow when chain passes the selected power of two
	wire [3:0] wdt_exp = 4'(WDT_EXP_MIN) + {2'h0, opt_tsel};
	// The extended view has a bit 15, so the 2^15 tap is the chain's own carry out
	wire [CHAIN_BITS:0] chain_ext = {1'b0, chain};
	wire [CHAIN_BITS:0] chain_next = chain_ext + 16'h0001;
	wire wdt_tap_carry = chain_next[wdt_exp] && !chain_ext[wdt_exp];
	wire overflow = src_tick && opt_wdt_en && wdt_tap_carry;

	// Instruction clock divider runs on the system clock
	always_ff @(posedge clk_i) begin
		if (rst_i || halted)
			instr_div <= 2'h0;
		else
			instr_div <= instr_div + 2'h1;
	end

	// Divider and prescaler chain; shared taps restart with every watchdog clear
	always_ff @(posedge clk_i) begin
		if (rst_i || wdt_clear || overflow)
			chain <= '0;
		else if (src_tick)
			chain <= chain_next[CHAIN_BITS-1:0];
	end

	// Pair tracking: the first half is remembered until the pair completes or a halt command
	always_ff @(posedge clk_i) begin
		if (rst_i || pair_done || cmd_halt)
			pair_first_seen <= 1'b0;
		else if (cmd_first)
			pair_first_seen <= 1'b1;
	end

	// Halt state; a halted overflow is also a wake source
	always_ff @(posedge clk_i) begin
		if (rst_i || cmd_wake || (overflow && halted))
			halted <= 1'b0;
		else if (cmd_halt)
			halted <= 1'b1;
	end

	// Flags: time-out set wins over a same-cycle clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			timeout_flag <= 1'b0;
			powerdown_flag <= 1'b0;
		end else begin
			if (overflow)
				timeout_flag <= 1'b1;
			else if (sw_clear || cmd_halt)
				timeout_flag <= 1'b0;
			if (cmd_halt)
				powerdown_flag <= 1'b1;
			else if (sw_clear)
				powerdown_flag <= 1'b0;
		end
	end

	// Resets are one-cycle pulses; the kind depends on halt state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			chip_reset_o <= 1'b0;
			warm_reset_o <= 1'b0;
		end else begin
			chip_reset_o <= overflow && !halted;
			warm_reset_o <= overflow && halted;
		end
	end

	// RTC control register; quick start bit drives the crystal
	always_ff @(posedge clk_i) begin
		if (rst_i)
			rtc_control_register <= RTC_CONTROL_REGISTER_RESET;
		else if (wr_rtc_control_register)
			rtc_control_register <= dat_i[7:0];
	end

	// Taps; LCD and buzzer select codes saturate at their top exponent
	wire [3:0] lcd_exp = ({1'b0, opt_lcd} > 4'(LCD_EXP_MAX - LCD_EXP_MIN)) ?
		4'(LCD_EXP_MAX) : 4'(LCD_EXP_MIN) + {1'b0, opt_lcd};
	wire [3:0] buz_exp = 4'(BUZ_EXP_MIN) + {1'b0, opt_buz};
	wire lcd_tap = chain[lcd_exp - 4'h1];
	wire buz_tap = (buz_exp > 4'(BUZ_EXP_MAX)) ? chain[BUZ_EXP_MAX-1] : chain[buz_exp - 4'h1];

	// Clock outputs registered; osc pin only toggles in RC mode, held high otherwise
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lcd_clk_o <= 1'b0;
			buzzer_clk_o <= 1'b0;
			osc_output_pin_o <= 1'b1;
			sys_osc_run_o <= 1'b1;
			quick_start_osc_o <= 1'b0;
			timeout_status_flag_o <= 1'b0;
			powerdown_flag_o <= 1'b0;
		end else begin
			lcd_clk_o <= lcd_tap;
			buzzer_clk_o <= buz_tap;
			osc_output_pin_o <= opt_rc_mode ? instr_div[1] : 1'b1;
			sys_osc_run_o <= !(halted || cmd_halt) || cmd_wake;
			quick_start_osc_o <= rtc_control_register[QUICK_START_BIT];
			timeout_status_flag_o <= timeout_flag;
			powerdown_flag_o <= powerdown_flag;
		end
	end

	// Read mux
	wire [31:0] rd_data = (adr_i == CTRL_ADDR) ?
		{20'h0, opt_buz, opt_lcd, opt_paired, opt_tsel, opt_src, opt_wdt_en} :
		(adr_i == STATUS_ADDR) ?
		{26'h0, timeout_flag, powerdown_flag, 3'h0, halted} :
		(adr_i == RTC_CONTROL_REGISTER_ADDR) ? {24'h0, rtc_control_register} :
		(adr_i == CMD_ADDR) ? {31'h0, pair_first_seen} : 32'h0;

	// Single-wait ack; unmapped reads return zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack <= 1'b0;
			dat_o <= 32'h0;
		end else begin
			ack <= bus_req;
			dat_o <= bus_req ? rd_data : 32'h0;
		end
	end
	assign ack_o = ack;

endmodule : wdt_timer

// >>> tb/wdt_timer_asserts.sv
`timescale 1ns/1ns
module wdt_timer_asserts (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic ack_o,
	input wire logic chip_reset_o,
	input wire logic warm_reset_o,
	input wire logic sys_osc_run_o,
	input wire logic timeout_status_flag_o,
	input wire logic powerdown_flag_o
);
	// One domain, so clock and reset are given once
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Bus timing: fixed one-cycle answer, one-cycle pulse
	chk_ack_one_cycle: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("ack not one cycle after request");
	chk_ack_single: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	// Kind of reset follows the run state before the overflow
	chk_normal_reset: assert property (chip_reset_o |-> $past(sys_osc_run_o))
		else $error("chip reset while halted");
	chk_halt_warm: assert property (warm_reset_o |-> !$past(sys_osc_run_o))
		else $error("warm reset while running");
	chk_reset_kinds: assert property (!(chip_reset_o && warm_reset_o))
		else $error("both reset kinds at once");
	// Flags follow overflow and halt within two cycles
	chk_flag_sets: assert property (chip_reset_o |-> ##[0:2] timeout_status_flag_o)
		else $error("timeout flag not set");
	chk_warm_flag: assert property (warm_reset_o |-> ##[0:2] timeout_status_flag_o)
		else $error("timeout flag not set in halt");
	chk_halt_pdf: assert property ($fell(sys_osc_run_o) |-> ##[0:2] powerdown_flag_o)
		else $error("powerdown flag not set");
	chk_halt_clr_to: assert property ($fell(sys_osc_run_o) |-> ##[0:2] !timeout_status_flag_o)
		else $error("timeout flag not cleared by halt");
	cov_chip: cover property (chip_reset_o);
	cov_warm: cover property (warm_reset_o);
	cov_halt: cover property ($fell(sys_osc_run_o));
endmodule : wdt_timer_asserts
bind wdt_timer wdt_timer_asserts u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .chip_reset_o,
	.warm_reset_o, .sys_osc_run_o, .timeout_status_flag_o, .powerdown_flag_o);

// >>> tb/wdt_timer_tb.sv
`timescale 1ns/1ns
module wdt_timer_tb import wdt_timer_pkg::*;;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
	logic [3:0] adr_i = 4'h0, sel_i = 4'hF;
	logic [31:0] dat_i = 32'h0, dat_o, q;
	logic ack_o, chip_reset_o, warm_reset_o, sys_osc_run_o, osc_output_pin_o, lcd_clk_o;
	logic buzzer_clk_o, quick_start_osc_o, timeout_status_flag_o, powerdown_flag_o;
	logic watchdog_rc_oscillator_tick_i = 1'b1, rtc_crystal_oscillator_tick_i = 1'b0, wdt_enable_opt_i = 1'b1;
	logic watchdog_rc_oscillator_enable_opt_i = 1'b1, paired_clear_opt_i = 1'b0, rc_osc_mode_opt_i = 1'b1;
	logic [1:0] clk_src_opt_i = 2'h0, timeout_sel_opt_i = 2'h0;
	// Lowest LCD tap; with slow real ticks this is the one nearest 4kHz
	logic [2:0] lcd_sel_opt_i = 3'h0, buz_sel_opt_i = 3'h1;
	int err_total = 0, checks_done = 0, n;
	wdt_timer dut (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.cyc_i(cyc_i),
		.stb_i(stb_i),
		.we_i(we_i),
		.adr_i(adr_i),
		.sel_i(sel_i),
		.dat_i(dat_i),
		.dat_o(dat_o),
		.ack_o(ack_o),
		.watchdog_rc_oscillator_tick_i(watchdog_rc_oscillator_tick_i),
		.rtc_crystal_oscillator_tick_i(rtc_crystal_oscillator_tick_i),
		.wdt_enable_opt_i(wdt_enable_opt_i),
		.watchdog_rc_oscillator_enable_opt_i(watchdog_rc_oscillator_enable_opt_i),
		.clk_src_opt_i(clk_src_opt_i),
		.timeout_sel_opt_i(timeout_sel_opt_i),
		.paired_clear_opt_i(paired_clear_opt_i),
		.rc_osc_mode_opt_i(rc_osc_mode_opt_i),
		.lcd_sel_opt_i(lcd_sel_opt_i),
		.buz_sel_opt_i(buz_sel_opt_i),
		.chip_reset_o(chip_reset_o),
		.warm_reset_o(warm_reset_o),
		.sys_osc_run_o(sys_osc_run_o),
		.osc_output_pin_o(osc_output_pin_o),
		.lcd_clk_o(lcd_clk_o),
		.buzzer_clk_o(buzzer_clk_o),
		.quick_start_osc_o(quick_start_osc_o),
		.timeout_status_flag_o(timeout_status_flag_o),
		.powerdown_flag_o(powerdown_flag_o)
	);
	// 100 ns period
	always #50 clk_i = ~clk_i;
	task automatic close_out;
		if (err_total == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : close_out
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	// Holds the request until ack is sampled; bounded so a dead slave cannot hang us
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		for (n = 0; ack_o !== 1'b1; n++) begin
			if (n > 20) begin
				chk("ack", 32'h1, 32'h0);
				close_out();
			end
			@(posedge clk_i);
		end
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask : wb
	// Expected event: running out of cycles is a failure
	task automatic until_high(ref logic s, input int lim);
		for (n = 0; s !== 1'b1; n++) begin
			if (n >= lim) begin
				chk("wait", 32'h1, 32'h0);
				close_out();
			end
			@(posedge clk_i);
		end
	endtask : until_high
	// Quiet window: n reaches lim only if the signal stayed low throughout
	task automatic quiet(ref logic s, input int lim);
		for (n = 0; s !== 1'b1 && n < lim; n++) @(posedge clk_i);
	endtask : quiet
	// Counts rising edges over 64 cycles of an undisturbed chain
	task automatic rises(ref logic s, input int exp_n, input string nm);
		logic prev;
		int c;
		prev = s;
		c = 0;
		repeat (64) begin
			@(posedge clk_i);
			if (s && !prev)
				c++;
			prev = s;
		end
		chk(nm, 32'(exp_n), 32'(c));
	endtask : rises
	// Options change only while reset is held
	task automatic rst(input logic en, input logic pr);
		@(posedge clk_i);
		rst_i <= 1'b1;
		wdt_enable_opt_i <= en;
		paired_clear_opt_i <= pr;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
	endtask : rst
	initial begin
		rst(1'b1, 1'b0);
		wb(1'b0, STATUS_ADDR, 32'h0);
		chk("status", 32'h0, q);
		wb(1'b1, RTC_CONTROL_REGISTER_ADDR, 32'h10);
		wb(1'b1, 4'h2, 32'hFF);
		wb(1'b0, RTC_CONTROL_REGISTER_ADDR, 32'h0);
		chk("rtc_control_register", 32'h10, q);
		chk("quick_start_osc_bit", 32'h1, 32'(quick_start_osc_o));
		until_high(chip_reset_o, 5000);
		chk("ovf", 32'h1, 32'(n > 4070 && n < 4100));
		wb(1'b0, STATUS_ADDR, 32'h0);
		chk("to", 32'h20, q & 32'h20);
		rises(lcd_clk_o, 16, "lcd");
		rises(buzzer_clk_o, 8, "buz");
		rises(osc_output_pin_o, 16, "osc_output_pin");
		// Clears 3000 cycles apart keep the count below 2^12
		repeat (2) begin
			wb(1'b1, CMD_ADDR, 32'h1 << CMD_SINGLE_CLR);
			quiet(chip_reset_o, 3000);
			chk("clr", 32'hBB8, 32'(n));
		end
		wb(1'b1, CMD_ADDR, 32'h1 << CMD_HALT);
		chk("run", 32'h0, 32'(sys_osc_run_o));
		wb(1'b0, STATUS_ADDR, 32'h0);
		chk("halt", 32'h11, q & 32'h31);
		until_high(warm_reset_o, 5000);
		chk("warm", 32'h1, 32'(n < 4100));
		wb(1'b0, STATUS_ADDR, 32'h0);
		chk("wto", 32'h30, q & 32'h30);
		wb(1'b1, CMD_ADDR, 32'h1 << CMD_WAKE);
		// Paired scheme: a lone first or single command must not clear
		rst(1'b1, 1'b1);
		repeat (2000) @(posedge clk_i);
		wb(1'b1, CMD_ADDR, 32'h1 << CMD_PAIR_FIRST);
		wb(1'b1, CMD_ADDR, 32'h1 << CMD_SINGLE_CLR);
		until_high(chip_reset_o, 3000);
		chk("pair1", 32'h1, 32'(n < 2200));
		repeat (2000) @(posedge clk_i);
		wb(1'b1, CMD_ADDR, 32'h1 << CMD_PAIR_FIRST);
		wb(1'b1, CMD_ADDR, 32'h1 << CMD_PAIR_SECOND);
		quiet(chip_reset_o, 3000);
		chk("pair2", 32'hBB8, 32'(n));
		rst(1'b0, 1'b0);
		quiet(chip_reset_o, 5000);
		chk("off", 32'h1388, 32'(n));
		close_out();
	end
endmodule : wdt_timer_tb
